// *** lfs_core.sv ***
// Functional notes
// - mode bits 2:1 pick converter span 30, 60, 80 or 100 mT.
// - mode word also picks the low-pass filter corner.
// - two-bit span code picks the linear temperature compensation band.
// - sensitivity corrected by linear and quadratic temperature coefficients.
// - signed field sample is low-pass filtered then processed per stored configuration.
// - gain word drives a signed multiplier, range -0.25 to just under 0.25.
// - offset word drives an adder setting zero-field output.
// - lower clamp programmable 0 to half supply in two-code steps.
// - upper clamp programmable 0 to full supply in two-code steps.
// - final processed value readable through the readout word.
// - lock bit set means every programming command is ignored.
// - lock takes effect only after the next power cycle.
// - lock bit can never be cleared.
// - accepted command reads or writes memory and replies on output pin.
// - only the device selected through its output pin answers.
// - factory trim words are never altered after production.
`timescale 1ns/1ps
`include "lfs_regs.svh"

module lfs_core import lfs_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire lfs_sample_t smp,
	input wire lfs_cmd_t cmd,
	input wire logic dev_sel,
	output lfs_rsp_t rsp,
	output logic [9:0] dac_code,
	output logic [1:0] range_sel,
	output logic [15:0] trim_osc,
	output logic [15:0] trim_adc,
	output logic locked,
	output logic ready
);

	////////////////////////////////////////////////////////////////////////////////
	// boot sequencing and storage

	lfs_state_t state_reg;
	logic ready_reg;
	logic [3:0] boot_addr_reg;
	logic ld_valid_reg;
	logic [3:0] ld_addr_reg;
	logic locked_reg;
	logic [15:0] shadow_reg [`LFS_NUM_WORDS];
	logic [15:0] nvm_rdata;
	logic [3:0] nvm_addr;
	logic nvm_we;
	logic [15:0] nvm_wdata;
	logic cmd_acc;
	logic wr_ok;
	lfs_rsp_t rsp_reg;
	logic [9:0] readout_reg;

	lfs_nvm u_nvm (
		.clk(clk),
		.we(nvm_we),
		.addr(nvm_addr),
		.wdata(nvm_wdata),
		.rdata(nvm_rdata)
	);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg <= LFS_ST_BOOT;
			ready_reg <= 1'b0;
		end else if (state_reg == LFS_ST_BOOT && ld_valid_reg && ld_addr_reg == `LFS_LAST_WORD) begin
			state_reg <= LFS_ST_RUN;
			ready_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			boot_addr_reg <= 4'h0;
			ld_valid_reg <= 1'b0;
			ld_addr_reg <= 4'h0;
		end else begin
			ld_valid_reg <= (state_reg == LFS_ST_BOOT) && !(ld_valid_reg && ld_addr_reg == `LFS_LAST_WORD);
			ld_addr_reg <= boot_addr_reg;
			if (state_reg == LFS_ST_BOOT && boot_addr_reg != `LFS_LAST_WORD) begin
				boot_addr_reg <= boot_addr_reg + 4'h1;
			end
		end
	end

	// the stored lock bit is sampled only while booting, so a fresh lock waits for a power cycle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			locked_reg <= 1'b0;
		end else if (ld_valid_reg && ld_addr_reg == `LFS_ADDR_LOCK) begin
			locked_reg <= nvm_rdata[`LFS_LOCK_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// programming commands

	assign cmd_acc = state_reg == LFS_ST_RUN && cmd.valid && dev_sel && !locked_reg;
	// readout is live state and trim words are production-only
	assign wr_ok = cmd_acc && cmd.write && cmd.addr <= `LFS_ADDR_LOCK
		&& cmd.addr != `LFS_ADDR_READOUT;

	always_comb begin
		nvm_addr = (state_reg == LFS_ST_BOOT) ? boot_addr_reg : cmd.addr;
		nvm_we = wr_ok;
		if (cmd.addr == `LFS_ADDR_LOCK) begin
			nvm_wdata = {14'h0000, shadow_reg[`LFS_ADDR_LOCK][1:0] | cmd.wdata[1:0]};
		end else begin
			nvm_wdata = cmd.wdata;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `LFS_NUM_WORDS; gi++) begin : g_shadow
			always_ff @(posedge clk) begin
				if (!rstn) begin
					shadow_reg[gi] <= `LFS_WORD_RST;
				end else if (ld_valid_reg && ld_addr_reg == 4'(gi)) begin
					shadow_reg[gi] <= nvm_rdata;
				end else if (wr_ok && cmd.addr == 4'(gi)) begin
					shadow_reg[gi] <= nvm_wdata;
				end
			end
		end
	endgenerate

	// one reply per accepted command, one cycle later
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg.valid <= cmd_acc;
			if (!cmd_acc) begin
				rsp_reg.rdata <= 16'h0000;
			end else if (cmd.write) begin
				rsp_reg.rdata <= wr_ok ? nvm_wdata : (cmd.addr <= `LFS_LAST_WORD) ? shadow_reg[cmd.addr] : 16'h0000;
			end else if (cmd.addr == `LFS_ADDR_READOUT) begin
				rsp_reg.rdata <= {6'h00, readout_reg};
			end else if (cmd.addr <= `LFS_LAST_WORD) begin
				rsp_reg.rdata <= shadow_reg[cmd.addr];
			end else begin
				rsp_reg.rdata <= 16'h0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration fields

	logic [1:0] filt_code;
	logic [2:0] filt_shift;
	logic [10:0] tc_lin;
	logic signed [7:0] tc_quad;
	logic [1:0] tc_span;
	logic signed [15:0] gain;
	logic signed [10:0] offset;
	logic [9:0] lo10;
	logic [9:0] hi10;
	logic signed [12:0] span_base;

	assign filt_code = shadow_reg[`LFS_ADDR_MODE][`LFS_FILT_MSB:`LFS_FILT_LSB];
	assign filt_shift = {1'b0, filt_code} + `LFS_FILT_BASE;
	assign tc_lin = shadow_reg[`LFS_ADDR_TC_LIN][10:0];
	assign tc_quad = $signed(shadow_reg[`LFS_ADDR_TC_QUAD][7:0]);
	assign tc_span = shadow_reg[`LFS_ADDR_TC_SPAN][1:0];
	assign gain = $signed(shadow_reg[`LFS_ADDR_GAIN]);
	assign offset = $signed(shadow_reg[`LFS_ADDR_OFFSET][10:0]);
	// limits count 9.77 mV steps, twice the 4.9 mV output code
	assign lo10 = {1'b0, shadow_reg[`LFS_ADDR_CLAMP_LO][7:0], 1'b0};
	assign hi10 = {shadow_reg[`LFS_ADDR_CLAMP_HI][8:0], 1'b0};

	always_comb begin
		unique case (tc_span)
			2'b00: span_base = `LFS_SPAN_00;
			2'b10: span_base = `LFS_SPAN_10;
			2'b01: span_base = `LFS_SPAN_01;
			2'b11: span_base = `LFS_SPAN_11;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// signal chain: filter, temperature, gain, offset, clamp

	logic signed [15:0] filt_reg;
	logic signed [7:0] temp_reg;
	logic v1_reg;
	logic v2_reg;
	logic v3_reg;
	logic v4_reg;
	logic v5_reg;
	logic signed [17:0] comp_reg;
	logic signed [20:0] scaled_reg;
	logic signed [20:0] sum_reg;
	logic signed [16:0] diff;
	logic signed [16:0] step;
	logic signed [12:0] coeff;
	logic signed [15:0] dt2;
	logic signed [20:0] lin;
	logic signed [23:0] quad;
	logic signed [24:0] corr;
	logic signed [40:0] prod;
	logic signed [33:0] gprod;
	logic signed [20:0] lo_s;
	logic signed [20:0] hi_s;

	assign diff = 17'(smp.field) - 17'(filt_reg);
	assign step = diff >>> filt_shift;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			filt_reg <= 16'sh0000;
			temp_reg <= 8'sh00;
		end else if (smp.valid && state_reg == LFS_ST_RUN) begin
			filt_reg <= filt_reg + step[15:0];
			temp_reg <= smp.temp;
		end
	end

	assign coeff = span_base + $signed({2'b00, tc_lin});
	assign dt2 = temp_reg * temp_reg;
	assign lin = coeff * temp_reg;
	assign quad = tc_quad * dt2;
	assign corr = 25'(lin) + 25'(quad);
	assign prod = filt_reg * corr;
	assign gprod = comp_reg * gain;
	assign lo_s = $signed({11'h000, lo10});
	assign hi_s = $signed({11'h000, hi10});

	always_ff @(posedge clk) begin
		if (!rstn) begin
			v1_reg <= 1'b0;
			v2_reg <= 1'b0;
			v3_reg <= 1'b0;
			v4_reg <= 1'b0;
			v5_reg <= 1'b0;
		end else begin
			v1_reg <= smp.valid && state_reg == LFS_ST_RUN;
			v2_reg <= v1_reg;
			v3_reg <= v2_reg;
			v4_reg <= v3_reg;
			v5_reg <= v4_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			comp_reg <= 18'sh00000;
		end else if (v1_reg) begin
			comp_reg <= 18'(filt_reg) + 18'(prod >>> `LFS_TC_SHIFT);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			scaled_reg <= 21'sh000000;
		end else if (v2_reg) begin
			scaled_reg <= 21'(gprod >>> `LFS_GAIN_SHIFT);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sum_reg <= 21'sh000000;
		end else if (v3_reg) begin
			sum_reg <= scaled_reg + 21'(offset);
		end
	end

	// when the limits cross, sums below the low limit take the low limit and all other sums take the high limit
	always_ff @(posedge clk) begin
		if (!rstn) begin
			readout_reg <= `LFS_CODE_RST;
		end else if (v4_reg) begin
			if (sum_reg < lo_s) begin
				readout_reg <= lo10;
			end else if (sum_reg > hi_s) begin
				readout_reg <= hi10;
			end else begin
				readout_reg <= sum_reg[9:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign rsp = rsp_reg;
	assign dac_code = readout_reg;
	assign range_sel = shadow_reg[`LFS_ADDR_MODE][`LFS_RANGE_MSB:`LFS_RANGE_LSB];
	assign trim_osc = shadow_reg[`LFS_ADDR_TRIM_OSC];
	assign trim_adc = shadow_reg[`LFS_ADDR_TRIM_ADC];
	assign locked = locked_reg;
	assign ready = ready_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	chk_locked_silent: assert property (@(posedge clk) disable iff (!rstn)
		locked_reg && cmd.valid |=> !rsp_reg.valid)
		else $error("locked device replied to a command");

	chk_lock_deferred: assert property (@(posedge clk) disable iff (!rstn)
		state_reg == LFS_ST_RUN && $past(state_reg == LFS_ST_RUN) |-> $stable(locked_reg))
		else $error("lock changed without a power cycle");

	chk_lock_sticky: assert property (@(posedge clk) disable iff (!rstn)
		ready && shadow_reg[`LFS_ADDR_LOCK][0] |=> shadow_reg[`LFS_ADDR_LOCK][0])
		else $error("lock bit was cleared");

	chk_cmd_reply: assert property (@(posedge clk) disable iff (!rstn)
		cmd_acc |=> rsp_reg.valid ##1 !rsp_reg.valid || $past(cmd_acc))
		else $error("accepted command got no reply");

	chk_sel_gate: assert property (@(posedge clk) disable iff (!rstn)
		rsp_reg.valid |-> $past(dev_sel) && $past(cmd.valid))
		else $error("reply without device selection");

	chk_trim_fixed: assert property (@(posedge clk) disable iff (!rstn)
		nvm_we |-> nvm_addr != `LFS_ADDR_TRIM_OSC && nvm_addr != `LFS_ADDR_TRIM_ADC)
		else $error("trim word written");

	chk_locked_nowrite: assert property (@(posedge clk) disable iff (!rstn)
		locked_reg |-> !nvm_we)
		else $error("storage written while locked");

	chk_pipe_latency: assert property (@(posedge clk) disable iff (!rstn)
		smp.valid && ready |-> ##`LFS_PIPE_DEPTH v5_reg)
		else $error("sample did not reach the output in five cycles");

	chk_clamp_low: assert property (@(posedge clk) disable iff (!rstn)
		v5_reg && $past(v4_reg) |-> readout_reg >= $past(lo10))
		else $error("output below lower limit");

	chk_clamp_high: assert property (@(posedge clk) disable iff (!rstn)
		v5_reg && $past(lo10) <= $past(hi10) |-> readout_reg <= $past(hi10))
		else $error("output above upper limit");

	chk_readout_reply: assert property (@(posedge clk) disable iff (!rstn)
		cmd_acc && !cmd.write && cmd.addr == `LFS_ADDR_READOUT && !v4_reg
		|=> rsp_reg.rdata == {6'h00, readout_reg})
		else $error("readout reply differs from output code");

	cov_boot_done: cover property (@(posedge clk) disable iff (!rstn) $rose(ready));
	cov_write_acc: cover property (@(posedge clk) disable iff (!rstn) wr_ok);
	cov_lock_write: cover property (@(posedge clk) disable iff (!rstn) wr_ok && cmd.addr == `LFS_ADDR_LOCK);
	cov_clamp_hit: cover property (@(posedge clk) disable iff (!rstn) v4_reg && sum_reg > hi_s);

endmodule : lfs_core

// *** lfs_nvm.sv ***
`timescale 1ns/1ps
`include "lfs_regs.svh"

module lfs_nvm (
	input wire logic clk,
	input wire logic we,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata
);

	// erased array; contents survive rstn like the real cells
	logic [15:0] mem [`LFS_NUM_WORDS] = '{default: `LFS_WORD_RST};

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		rdata <= mem[addr];
	end

endmodule : lfs_nvm

// *** lfs_pkg.sv ***
package lfs_pkg;

	typedef enum {LFS_ST_BOOT, LFS_ST_RUN} lfs_state_t;

	// decoded programming command from the supply-modulation front end
	typedef struct packed {
		logic valid;
		logic write;
		logic [3:0] addr;
		logic [15:0] wdata;
	} lfs_cmd_t;

	// reply word sent back on the output pin
	typedef struct packed {
		logic valid;
		logic [15:0] rdata;
	} lfs_rsp_t;

	// converter sample with the die temperature relative to 25 C
	typedef struct packed {
		logic valid;
		logic signed [15:0] field;
		logic signed [7:0] temp;
	} lfs_sample_t;

endpackage : lfs_pkg

// *** lfs_prog_model.sv ***
`timescale 1ns/1ps

module lfs_prog_model import lfs_pkg::*; (
	input wire logic clk,
	input wire lfs_rsp_t rsp,
	output lfs_cmd_t cmd,
	output logic dev_sel
);
	logic [15:0] junk_reg;

	initial begin
		cmd = '0;
		dev_sel = 1'b0;
		junk_reg = 16'hA5C3;
	end

	// idle fields keep changing so a stale address or data can never pass for a request
	always @(posedge clk) begin
		junk_reg <= {junk_reg[14:0], junk_reg[15] ^ junk_reg[13]};
	end

	////////////////////////////////////////////////////////////////////////////////
	// one command word; gap idle cycles first so slow stations are covered too
	task automatic xfer(input logic wr, input logic [3:0] addr, input logic [15:0] data, input logic sel,
		input int gap, output logic got, output logic [15:0] rdata);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		cmd <= '{valid: 1'b1, write: wr, addr: addr, wdata: data};
		dev_sel <= sel;
		@(posedge clk);
		cmd <= '{valid: 1'b0, write: junk_reg[0], addr: junk_reg[4:1], wdata: junk_reg};
		dev_sel <= 1'b0;
		#1;
		got = rsp.valid;
		rdata = rsp.rdata;
	endtask : xfer
endmodule : lfs_prog_model

// *** lfs_regs.svh ***
`ifndef LFS_REGS_SVH
`define LFS_REGS_SVH

// configuration word addresses
`define LFS_ADDR_MODE 4'h0
`define LFS_ADDR_TC_LIN 4'h1
`define LFS_ADDR_TC_QUAD 4'h2
`define LFS_ADDR_TC_SPAN 4'h3
`define LFS_ADDR_GAIN 4'h4
`define LFS_ADDR_OFFSET 4'h5
`define LFS_ADDR_CLAMP_LO 4'h6
`define LFS_ADDR_CLAMP_HI 4'h7
`define LFS_ADDR_READOUT 4'h8
`define LFS_ADDR_LOCK 4'h9
`define LFS_ADDR_TRIM_OSC 4'hA
`define LFS_ADDR_TRIM_ADC 4'hB
`define LFS_LAST_WORD 4'hB
`define LFS_NUM_WORDS 12

// field positions
`define LFS_RANGE_LSB 1
`define LFS_RANGE_MSB 2
`define LFS_FILT_LSB 3
`define LFS_FILT_MSB 4
`define LFS_LOCK_BIT 0

// reset and arithmetic constants
`define LFS_WORD_RST 16'h0000
`define LFS_CODE_RST 10'h000
`define LFS_FILT_BASE 3'h1
`define LFS_TC_SHIFT 20
`define LFS_GAIN_SHIFT 17
`define LFS_PIPE_DEPTH 5

// temperature coefficient span bases, ppm/K
`define LFS_SPAN_00 (-(13'sh0C1C))
`define LFS_SPAN_10 (-(13'sh06D6))
`define LFS_SPAN_01 (-(13'sh0226))
`define LFS_SPAN_11 (13'sh01C2)

`endif

// *** linear_field_sensor_processing_tb.sv ***
`timescale 1ns/1ps

module linear_field_sensor_processing_tb import lfs_pkg::*;;
	logic clk, rstn, dev_sel, locked, ready;
	lfs_sample_t smp;
	lfs_cmd_t cmd;
	lfs_rsp_t rsp;
	logic [9:0] dac_code;
	logic [1:0] range_sel;
	logic [15:0] trim_osc, trim_adc, lfsr_reg, d;
	logic [15:0] word_exp [8];
	int n_fail, n_compared, cyc, off, base;

	lfs_core u_dut (.clk(clk), .rstn(rstn), .smp(smp), .cmd(cmd), .dev_sel(dev_sel), .rsp(rsp),
		.dac_code(dac_code), .range_sel(range_sel), .trim_osc(trim_osc), .trim_adc(trim_adc),
		.locked(locked), .ready(ready));
	lfs_prog_model u_prog (.clk(clk), .rsp(rsp), .cmd(cmd), .dev_sel(dev_sel));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr

	// clamp of the gain and offset sum, with the lower limit checked first
	function automatic logic [15:0] exp_out(input int sum, input int lo, input int hi);
		if (sum < lo) return lo[15:0];
		if (sum > hi) return hi[15:0];
		return sum[15:0] & 16'h03FF;
	endfunction : exp_out

	// comp = f + f*(coef*t + q*t*t)/2^20, then Q.17 gain and offset; wide to avoid overflow
	function automatic int exp_chain(input int f, input int coef, input int q, input int t, input int g, input int o);
		longint c;
		c = f + ((longint'(f) * (coef * t + q * t * t)) >>> 20);
		return int'((c * g) >>> 17) + o;
	endfunction : exp_chain

	task automatic results();
		if (n_fail == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cmd_io(input logic wr, input logic [3:0] a, input logic [15:0] dd, input logic sel,
		input logic exp_got, input logic [15:0] exp_d);
		logic got;
		logic [15:0] rd;
		u_prog.xfer(wr, a, dd, sel, int'(lfsr_reg[1:0]), got, rd);
		lfsr_reg = lfsr(lfsr_reg);
		check({15'h0000, got}, {15'h0000, exp_got});
		if (exp_got) check(rd, exp_d);
	endtask : cmd_io

	task automatic wr(input logic [3:0] a, input logic [15:0] dd);
		cmd_io(1'b1, a, dd, 1'b1, 1'b1, dd);
	endtask : wr

	task automatic boot();
		int k;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		k = 0;
		@(posedge clk);
		#1;
		while (ready !== 1'b1 && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		check({15'h0000, ready}, 16'h0001);
	endtask : boot

	// n back-to-back samples, then let the chain settle
	task automatic feed(input int n, input logic [15:0] x, input logic [7:0] t);
		repeat (n) begin
			@(posedge clk);
			smp <= '{valid: 1'b1, field: x, temp: t};
		end
		@(posedge clk);
		smp <= '{valid: 1'b0, field: ~x, temp: 8'h5A};
		repeat (7) @(posedge clk);
		#1;
	endtask : feed

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		smp = '0;
		lfsr_reg = 16'h7A6B;
		n_fail = 0;
		n_compared = 0;
		cyc = 0;
		boot();
		for (int a = 0; a < 8; a++) begin
			d = lfsr_reg;
			lfsr_reg = lfsr(lfsr_reg);
			word_exp[a] = d;
			wr(a[3:0], d);
			cmd_io(1'b0, a[3:0], 16'h0000, 1'b1, 1'b1, d);
		end
		cmd_io(1'b1, 4'h4, ~word_exp[4], 1'b0, 1'b0, 16'h0000);
		cmd_io(1'b0, 4'h4, 16'h0000, 1'b1, 1'b1, word_exp[4]);
		cmd_io(1'b1, 4'hA, lfsr_reg, 1'b1, 1'b1, 16'h0000);
		cmd_io(1'b1, 4'hB, ~lfsr_reg, 1'b1, 1'b1, 16'h0000);
		check(trim_osc | trim_adc, 16'h0000);
		cmd_io(1'b0, 4'hD, 16'h0000, 1'b1, 1'b1, 16'h0000);
		cmd_io(1'b1, 4'hE, lfsr_reg, 1'b1, 1'b1, 16'h0000);
		for (int c = 0; c < 4; c++) begin
			wr(4'h0, {13'h0000, c[1:0], 1'b0});
			@(posedge clk);
			#1;
			check({14'h0000, range_sel}, {14'h0000, c[1:0]});
		end
		wr(4'h0, 16'h0000);
		wr(4'h4, 16'h0800);
		wr(4'h5, 16'h012C);
		wr(4'h6, 16'h0000);
		wr(4'h7, 16'h01FF);
		feed(40, 16'hF000, 8'h00);
		check({6'h00, dac_code}, exp_out(((-4096 * 2048) >>> 17) + 300, 0, 1022));
		cmd_io(1'b0, 4'h8, 16'h0000, 1'b1, 1'b1, exp_out(-64 + 300, 0, 1022));
		wr(4'h4, 16'h1000);
		feed(4, 16'hF000, 8'h00);
		check({6'h00, dac_code}, exp_out(((-4096 * 4096) >>> 17) + 300, 0, 1022));
		wr(4'h4, 16'h0000);
		wr(4'h6, 16'h0019);
		wr(4'h7, 16'h0190);
		for (int i = 0; i < 3; i++) begin
			off = (i == 0) ? -100 : (i == 1) ? 900 : 60 + int'(lfsr_reg % 16'd700);
			wr(4'h5, off[15:0] & 16'h07FF);
			feed(1, lfsr_reg, lfsr_reg[7:0]);
			check({6'h00, dac_code}, exp_out(off, 50, 800));
		end
		// filter settles from above onto full negative scale, gain 2048 (1/64), offset 768
		wr(4'h0, 16'h0000);
		wr(4'h4, 16'h0800);
		wr(4'h5, 16'h0300);
		wr(4'h6, 16'h0000);
		wr(4'h7, 16'h01FF);
		wr(4'h1, 16'h0064);
		wr(4'h2, 16'h00FB);
		feed(40, 16'h8000, 8'h00);
		check({6'h00, dac_code}, exp_out(exp_chain(-32768, 0, 0, 0, 2048, 768), 0, 1022));
		for (int s = 0; s < 4; s++) begin
			base = (s == 0) ? -3100 : (s == 1) ? -550 : (s == 2) ? -1750 : 450;
			wr(4'h3, {14'h0000, s[1:0]});
			feed(1, 16'h8000, 8'h64);
			check({6'h00, dac_code}, exp_out(exp_chain(-32768, base + 100, -5, 100, 2048, 768), 0, 1022));
		end
		// filter code 1 moves a quarter of the way in one sample, code 0 would move half
		wr(4'h0, 16'h0008);
		feed(1, 16'h0000, 8'h00);
		check({6'h00, dac_code}, exp_out(exp_chain(-32768 + (32768 >>> 2), 0, 0, 0, 2048, 768), 0, 1022));
		wr(4'h9, 16'h0001);
		cmd_io(1'b1, 4'h9, 16'h0000, 1'b1, 1'b1, 16'h0001);
		check({15'h0000, locked}, 16'h0000);
		wr(4'h0, 16'h0006);
		boot();
		check({15'h0000, locked}, 16'h0001);
		cmd_io(1'b1, 4'h0, 16'h0000, 1'b1, 1'b0, 16'h0000);
		cmd_io(1'b0, 4'h9, 16'h0000, 1'b1, 1'b0, 16'h0000);
		boot();
		check({15'h0000, locked}, 16'h0001);
		check({14'h0000, range_sel}, 16'h0003);
		results();
	end
endmodule : linear_field_sensor_processing_tb
